// ===== design/hlv_map.vh
// register map, field positions, reset values and timing constants of the humidity limit evaluator
`ifndef HLV_MAP_VH
`define HLV_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define HLV_CTRL_OFS      8'h00
`define HLV_STATUS_OFS    8'h04
`define HLV_HUMCFG_OFS    8'h08
`define HLV_CH_BASE_OFS   8'h10
`define HLV_CH_STRIDE     8'h10
`define HLV_LCFG_OFS      8'h00
`define HLV_LTHR_OFS      8'h04
`define HLV_LEFF_OFS      8'h08

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define HLV_CTRL_EN_BIT   0
`define HLV_CTRL_DL_BIT   1

// ----------------------------------------------------------------------------
// limit configuration fields
// ----------------------------------------------------------------------------
`define HLV_LC_FALL_BIT   0
`define HLV_LC_ASET_LSB   1
`define HLV_LC_ACLR_LSB   3
`define HLV_LC_SRC_LSB    5
`define HLV_LC_OND_LSB    7
`define HLV_LC_OFFD_LSB   11
`define HLV_LC_SOC_BIT    15
`define HLV_LC_CYC_LSB    16
`define HLV_LC_HYS_LSB    24

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define HLV_ACT_NONE      2'h0
`define HLV_ACT_OFF       2'h1
`define HLV_ACT_ON        2'h2
`define HLV_SRC_CFG       2'h0
`define HLV_SRC_WIDE      2'h1
`define HLV_SRC_NARROW    2'h2
`define HLV_SRC_TEACH     2'h3

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define HLV_CTRL_RST      32'h0000_0000
`define HLV_LCFG_RST      32'h0000_0000
`define HLV_LTHR_RST      16'h1388
`define HLV_HUMCFG_RST    32'h0000_0000
`define HLV_RANGE_MAX     16'h2710
`define HLV_CLK_HZ        100000000
`define HLV_CYC_STEP_S    10
`define HLV_DBYTE_MAX     24'h0000ff

`endif

// ===== design/hlv_evaluator.v
// humidity limit value evaluator with AHB-Lite register slave
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hlv_map.vh"

module hlv_evaluator #(
    parameter NCH = 2,
    parameter CLK_HZ = `HLV_CLK_HZ
) (
    // clock and reset
    input wire CLK_SYS_I,
    input wire SYS_RST_I,
    // ahb-lite slave
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output reg [31:0] HRDATA_O,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    // measured humidity, 0.01 %rh units
    input wire [15:0] HUM_VALUE_I,
    input wire HUM_VALID_I,
    // external threshold objects and teach pulses
    input wire [NCH-1:0] EXT_WR_I,
    input wire EXT_WIDE_I,
    input wire [15:0] EXT_DATA_I,
    input wire [NCH-1:0] TEACH_I,
    // outgoing telegrams
    output reg HUM_SEND_O,
    output reg [15:0] HUM_DATA_O,
    output reg [NCH-1:0] LIM_SEND_O,
    output reg [NCH-1:0] LIM_VALUE_O
);

// ----------------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------------
localparam [31:0] TICK_MAX = CLK_HZ - 1;
localparam integer HYS10_I = `HLV_RANGE_MAX / 10;
localparam integer HYS15_I = (`HLV_RANGE_MAX * 3) / 20;
localparam integer HYS20_I = `HLV_RANGE_MAX / 5;
localparam integer CYC_STEP_I = `HLV_CYC_STEP_S;
localparam [15:0] HYS10 = HYS10_I[15:0];
localparam [15:0] HYS15 = HYS15_I[15:0];
localparam [15:0] HYS20 = HYS20_I[15:0];
localparam [11:0] CYC_STEP = CYC_STEP_I[11:0];

// switch delay table in seconds
function [11:0] dly_secs;
    input [3:0] sel;
    begin
        case (sel)
            4'h0: dly_secs = 12'd0;
            4'h1: dly_secs = 12'd1;
            4'h2: dly_secs = 12'd3;
            4'h3: dly_secs = 12'd5;
            4'h4: dly_secs = 12'd10;
            4'h5: dly_secs = 12'd15;
            4'h6: dly_secs = 12'd30;
            4'h7: dly_secs = 12'd60;
            4'h8: dly_secs = 12'd180;
            4'h9: dly_secs = 12'd300;
            4'ha: dly_secs = 12'd600;
            4'hb: dly_secs = 12'd900;
            4'hc: dly_secs = 12'd1800;
            default: dly_secs = 12'd3600;
        endcase
    end
endfunction

// ----------------------------------------------------------------------------
// seconds timebase
// ----------------------------------------------------------------------------
reg [31:0] div_q;
reg sec_tick_q;

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        div_q <= 32'h0;
        sec_tick_q <= 1'b0;
    end else begin
        sec_tick_q <= (div_q == TICK_MAX);
        if (div_q == TICK_MAX) begin
            div_q <= 32'h0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
end

// ----------------------------------------------------------------------------
// ahb-lite slave: zero wait states, always okay
// ----------------------------------------------------------------------------
reg wr_pend_q;
reg [7:0] wr_addr_q;
wire addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
wire wr_en = wr_pend_q;
wire [31:0] wdata = HWDATA_I;
reg [31:0] ctrl_q;
reg [31:0] humcfg_q;
wire [32*NCH-1:0] ch_rd_cfg;
wire [16*NCH-1:0] ch_rd_thr;
wire [16*NCH-1:0] ch_rd_eff;
reg [31:0] rd_mux;
integer k;

assign HREADYOUT_O = 1'b1;
assign HRESP_O = 1'b0;

always @* begin
    rd_mux = 32'h0;
    case (HADDR_I[7:0])
        `HLV_CTRL_OFS: rd_mux = {31'h0, ctrl_q[`HLV_CTRL_EN_BIT]};
        `HLV_STATUS_OFS: rd_mux = {8'h0, 2'h0, LIM_VALUE_O[1:0], 4'h0, HUM_VALUE_I};
        `HLV_HUMCFG_OFS: rd_mux = humcfg_q;
        default: rd_mux = 32'h0;
    endcase
    for (k = 0; k < NCH; k = k + 1) begin
        if (HADDR_I[7:0] == `HLV_CH_BASE_OFS + k * `HLV_CH_STRIDE + `HLV_LCFG_OFS) begin
            rd_mux = ch_rd_cfg[32*k +: 32];
        end
        if (HADDR_I[7:0] == `HLV_CH_BASE_OFS + k * `HLV_CH_STRIDE + `HLV_LTHR_OFS) begin
            rd_mux = {16'h0, ch_rd_thr[16*k +: 16]};
        end
        if (HADDR_I[7:0] == `HLV_CH_BASE_OFS + k * `HLV_CH_STRIDE + `HLV_LEFF_OFS) begin
            rd_mux = {16'h0, ch_rd_eff[16*k +: 16]};
        end
    end
end

// read data captured at the address phase, so it stands during the data phase
always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        wr_pend_q <= 1'b0;
        wr_addr_q <= 8'h0;
        HRDATA_O <= 32'h0;
    end else begin
        wr_pend_q <= addr_ok && HWRITE_I;
        if (addr_ok) begin
            wr_addr_q <= HADDR_I[7:0];
        end
        if (addr_ok && !HWRITE_I) begin
            HRDATA_O <= rd_mux;
        end
    end
end

// download strobe is a self-clearing bit of the control register
wire download = wr_en && (wr_addr_q == `HLV_CTRL_OFS) && wdata[`HLV_CTRL_DL_BIT];
wire sensor_on = ctrl_q[`HLV_CTRL_EN_BIT];

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        ctrl_q <= `HLV_CTRL_RST;
        humcfg_q <= `HLV_HUMCFG_RST;
    end else begin
        if (wr_en && wr_addr_q == `HLV_CTRL_OFS) begin
            ctrl_q <= {31'h0, wdata[`HLV_CTRL_EN_BIT]};
        end
        if (wr_en && wr_addr_q == `HLV_HUMCFG_OFS) begin
            humcfg_q <= wdata;
        end
    end
end

// ----------------------------------------------------------------------------
// measured value object: difference and cyclic sending
// ----------------------------------------------------------------------------
reg [15:0] hum_last_q;
reg [11:0] hum_cyc_q;
wire [15:0] hum_diff = humcfg_q[15:0];
wire [7:0] hum_cyc_set = humcfg_q[23:16];
wire [15:0] hum_delta = (HUM_VALUE_I > hum_last_q) ? HUM_VALUE_I - hum_last_q : hum_last_q - HUM_VALUE_I;
wire hum_cyc_end = sec_tick_q && (hum_cyc_set != 8'h0) &&
    (hum_cyc_q + 12'h1 >= hum_cyc_set * CYC_STEP);
wire hum_diff_hit = HUM_VALID_I && (hum_diff != 16'h0) && (hum_delta >= hum_diff);

always @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
        hum_last_q <= 16'h0;
        hum_cyc_q <= 12'h0;
        HUM_SEND_O <= 1'b0;
        HUM_DATA_O <= 16'h0;
    end else begin
        HUM_SEND_O <= 1'b0;
        if (hum_cyc_end || hum_cyc_set == 8'h0) begin
            hum_cyc_q <= 12'h0;
        end else if (sec_tick_q) begin
            hum_cyc_q <= hum_cyc_q + 12'h1;
        end
        if (sensor_on && (hum_diff_hit || hum_cyc_end)) begin
            HUM_SEND_O <= 1'b1;
            HUM_DATA_O <= HUM_VALUE_I;
            hum_last_q <= HUM_VALUE_I;
        end
    end
end

// ----------------------------------------------------------------------------
// limit value channels
// ----------------------------------------------------------------------------
genvar g;
generate
for (g = 0; g < NCH; g = g + 1) begin : g_ch
    localparam integer BASE_I = `HLV_CH_BASE_OFS + g * `HLV_CH_STRIDE;
    localparam [7:0] BASE = BASE_I[7:0];
    reg [31:0] cfg_q;
    reg [15:0] thr_q;
    reg [15:0] ext_q;
    reg ext_valid_q;
    reg raw_q;
    reg obj_q;
    reg [11:0] dly_q;
    reg [11:0] cyc_q;
    wire fall = cfg_q[`HLV_LC_FALL_BIT];
    wire [1:0] act_set = cfg_q[`HLV_LC_ASET_LSB +: 2];
    wire [1:0] act_clr = cfg_q[`HLV_LC_ACLR_LSB +: 2];
    wire [1:0] src = cfg_q[`HLV_LC_SRC_LSB +: 2];
    wire soc = cfg_q[`HLV_LC_SOC_BIT];
    wire [7:0] cyc_set = cfg_q[`HLV_LC_CYC_LSB +: 8];
    wire [1:0] hys_sel = cfg_q[`HLV_LC_HYS_LSB +: 2];
    reg [15:0] hys;
    wire [23:0] narrow = ({16'h0, EXT_DATA_I[7:0]} * {8'h0, `HLV_RANGE_MAX}) / `HLV_DBYTE_MAX;
    wire [15:0] eff = (ext_valid_q && src != `HLV_SRC_CFG) ? ext_q : thr_q;
    wire [16:0] eff_hi = {1'b0, eff} + {1'b0, hys};
    wire [15:0] eff_lo = (eff > hys) ? eff - hys : 16'h0;
    wire above = HUM_VALUE_I > eff;
    wire below = HUM_VALUE_I < eff;
    wire set_cond = fall ? below : above;
    wire clr_cond = fall ? ({1'b0, HUM_VALUE_I} > eff_hi) : (HUM_VALUE_I < eff_lo);
    wire [1:0] act = raw_q ? act_set : act_clr;
    wire sendable = (act != `HLV_ACT_NONE);
    wire tgt = (act == `HLV_ACT_ON);
    wire pending = sendable && (tgt != obj_q);
    wire [11:0] dly_set = tgt ? dly_secs(cfg_q[`HLV_LC_OND_LSB +: 4]) : dly_secs(cfg_q[`HLV_LC_OFFD_LSB +: 4]);
    wire accept = pending && (dly_q >= dly_set);
    wire cyc_end = sec_tick_q && (cyc_set != 8'h0) && (cyc_q + 12'h1 >= cyc_set * CYC_STEP);
    wire ext_ok = EXT_WR_I[g] && ((src == `HLV_SRC_WIDE && EXT_WIDE_I) ||
        (src == `HLV_SRC_NARROW && !EXT_WIDE_I));

    always @* begin
        case (hys_sel)
            2'h1: hys = HYS10;
            2'h2: hys = HYS15;
            2'h3: hys = HYS20;
            default: hys = 16'h0;
        endcase
    end

    assign ch_rd_cfg[32*g +: 32] = {6'h0, cfg_q[25:0]};
    assign ch_rd_thr[16*g +: 16] = thr_q;
    assign ch_rd_eff[16*g +: 16] = eff;

    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            cfg_q <= `HLV_LCFG_RST;
            thr_q <= `HLV_LTHR_RST;
            ext_q <= 16'h0;
            ext_valid_q <= 1'b0;
        end else begin
            if (wr_en && wr_addr_q == BASE + `HLV_LCFG_OFS) begin
                cfg_q <= {6'h0, wdata[25:0]};
            end
            if (wr_en && wr_addr_q == BASE + `HLV_LTHR_OFS) begin
                thr_q <= wdata[15:0];
            end
            // fresh reception beats a download in the same cycle
            if (ext_ok) begin
                ext_q <= EXT_WIDE_I ? EXT_DATA_I : narrow[15:0];
                ext_valid_q <= 1'b1;
            end else if (TEACH_I[g] && src == `HLV_SRC_TEACH) begin
                ext_q <= HUM_VALUE_I;
                ext_valid_q <= 1'b1;
            end else if (download) begin
                ext_valid_q <= 1'b0;
            end
        end
    end

    // hysteresis band holds raw state; sensor off freezes evaluation
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            raw_q <= 1'b0;
        end else if (sensor_on) begin
            if (set_cond) begin
                raw_q <= 1'b1;
            end else if (clr_cond) begin
                raw_q <= 1'b0;
            end
        end
    end

    // delay counter restarts whenever the pending target disappears
    always @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            obj_q <= 1'b0;
            dly_q <= 12'h0;
            cyc_q <= 12'h0;
            LIM_SEND_O[g] <= 1'b0;
            LIM_VALUE_O[g] <= 1'b0;
        end else begin
            LIM_SEND_O[g] <= 1'b0;
            if (!pending || accept) begin
                dly_q <= 12'h0;
            end else if (sec_tick_q) begin
                dly_q <= dly_q + 12'h1;
            end
            if (cyc_end || cyc_set == 8'h0) begin
                cyc_q <= 12'h0;
            end else if (sec_tick_q) begin
                cyc_q <= cyc_q + 12'h1;
            end
            if (accept) begin
                obj_q <= tgt;
            end
            if (accept && soc) begin
                LIM_SEND_O[g] <= 1'b1;
                LIM_VALUE_O[g] <= tgt;
            end else if (cyc_end && sendable) begin
                // silent acceptance must not swallow a cyclic slot
                LIM_SEND_O[g] <= 1'b1;
                LIM_VALUE_O[g] <= accept ? tgt : obj_q;
            end
        end
    end
end
endgenerate

endmodule // hlv_evaluator
`default_nettype wire

// ===== verification/hlv_evaluator_props.sv
// port-level timing checker of the humidity limit evaluator
`timescale 1ns/100ps
`default_nettype none
module hlv_evaluator_props #(
    parameter NCH = 2,
    parameter CLK_HZ = 100000000
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    // bus answer
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // telegrams
    input wire logic HUM_SEND_O,
    input wire logic [15:0] HUM_DATA_O,
    input wire logic [NCH-1:0] LIM_SEND_O,
    input wire logic [NCH-1:0] LIM_VALUE_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);
    // --------
    // sequences
    // --------
    sequence s_pulse(sig);
        sig ##1 !sig;
    endsequence
    sequence s_sent_then_idle(sig);
        sig ##1 !sig [*2];
    endsequence
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O) else $error("bus answer not ready or error");
    a_reset_quiet: assert property ($fell(SYS_RST_I) |-> LIM_SEND_O == 0 && !HUM_SEND_O)
        else $error("telegram right after reset");
    a_lim_pulse0: assert property (LIM_SEND_O[0] |-> s_pulse(LIM_SEND_O[0]))
        else $error("limit 0 send not a single pulse");
    a_lim_pulse1: assert property (LIM_SEND_O[1] |-> s_pulse(LIM_SEND_O[1]))
        else $error("limit 1 send not a single pulse");
    a_val_hold0: assert property (!LIM_SEND_O[0] |-> $stable(LIM_VALUE_O[0]))
        else $error("limit 0 value moved without telegram");
    a_val_tie1: assert property ($changed(LIM_VALUE_O[1]) |-> LIM_SEND_O[1])
        else $error("limit 1 value moved without telegram");
    a_val_keep1: assert property (s_sent_then_idle(LIM_SEND_O[1]) |-> LIM_VALUE_O[1] == $past(LIM_VALUE_O[1], 2))
        else $error("limit 1 value not held after telegram");
    a_hum_pulse: assert property (HUM_SEND_O |-> s_pulse(HUM_SEND_O))
        else $error("humidity send not a single pulse");
    a_hum_tie: assert property ($changed(HUM_DATA_O) |-> HUM_SEND_O)
        else $error("humidity value moved without telegram");
endmodule // hlv_evaluator_props

bind hlv_evaluator hlv_evaluator_props #(.NCH(NCH), .CLK_HZ(CLK_HZ)) u_hlv_evaluator_props (
    .CLK_SYS_I(CLK_SYS_I),
    .SYS_RST_I(SYS_RST_I),
    .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O),
    .HUM_SEND_O(HUM_SEND_O),
    .HUM_DATA_O(HUM_DATA_O),
    .LIM_SEND_O(LIM_SEND_O),
    .LIM_VALUE_O(LIM_VALUE_O)
);
`default_nettype wire

// ===== verification/hlv_ext_src.sv
// external value transmitter model feeding threshold objects
`timescale 1ns/100ps
`default_nettype none
module hlv_ext_src (
    // request from the bench
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [1:0] ch_i,
    input wire logic wide_i,
    input wire logic [15:0] val_i,
    // object write toward the evaluator
    output logic [1:0] wr_o = 2'h0,
    output logic wide_o = 1'h0,
    output logic [15:0] data_o = 16'h0
);
    always @(posedge clk_i) begin
        wr_o <= go_i ? ch_i : 2'h0;
        if (go_i) begin
            wide_o <= wide_i;
            data_o <= wide_i ? val_i : {8'h00, val_i[7:0]};
        end else begin
            // released line: invert every bit each cycle, so the old value comes back every second cycle
            data_o <= ~data_o;
        end
    end
endmodule // hlv_ext_src
`default_nettype wire

// ===== verification/tb_hlv_evaluator.sv
// self-checking bench of the humidity limit evaluator
`timescale 1ns/100ps
`default_nettype none
module tb_hlv_evaluator;
    logic clk = 0, rst = 1, go = 0, gwide = 0, hwrite = 0, hvalid = 0, hrdy, hresp, hsend, ewide;
    logic [1:0] htrans = 0, gch = 0, teach = 0, ewr, lsend, lval;
    logic [31:0] haddr = 0, hwdata = 0, rdat, hrdata;
    logic [15:0] hum = 0, gval = 0, edata, hdata;
    int mismatches = 0, n_tests = 0, cyc = 0, v, hv;
    int fl[2], th[2], hy[2], st[2];
    int got[$], hq[$];
    hlv_evaluator #(.NCH(2), .CLK_HZ(10)) u_hlv_evaluator (.CLK_SYS_I(clk), .SYS_RST_I(rst), .HSEL_I(1'h1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .HUM_VALUE_I(hum),
        .HUM_VALID_I(hvalid), .EXT_WR_I(ewr), .EXT_WIDE_I(ewide), .EXT_DATA_I(edata), .TEACH_I(teach),
        .HUM_SEND_O(hsend), .HUM_DATA_O(hdata), .LIM_SEND_O(lsend), .LIM_VALUE_O(lval));
    hlv_ext_src u_hlv_ext_src (.clk_i(clk), .go_i(go), .ch_i(gch), .wide_i(gwide), .val_i(gval),
        .wr_o(ewr), .wide_o(ewide), .data_o(edata));
    initial begin
        forever #5 clk = ~clk;
    end
    // ----
    // telegram monitor and hang guard
    // ----
    always @(posedge clk) begin
        cyc++;
        if (hsend === 1'h1) hq.push_back(hdata);
        for (int c = 0; c < 2; c++) if (lsend[c] === 1'h1) got.push_back(c * 2 + lval[c]);
        if (cyc > 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ----
    // tasks
    // ----
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'h1);
        rdat = hrdata;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, 32'h0);
        chk(rdat, e);
    endtask
    task ext(input logic [1:0] c, input logic w, input logic [15:0] d);
        @(posedge clk);
        go <= 1'h1;
        gch <= c;
        gwide <= w;
        gval <= d;
        @(posedge clk);
        go <= 1'h0;
    endtask
    // model: next state from threshold, hysteresis and mode; d delay cycles, s sends expected
    task step(input int c, input int w, input int d, input int s);
        int n;
        n = fl[c] ? (w < th[c] ? 1 : (w > th[c] + hy[c] ? 0 : st[c])) : (w > th[c] ? 1 : (w < th[c] - hy[c] ? 0 : st[c]));
        @(posedge clk);
        hum <= w[15:0];
        if (d > 0) begin
            repeat (15) @(posedge clk);
            chk(got.size(), 0);
        end
        repeat (d + 8) @(posedge clk);
        chk(got.size(), (n != st[c] && s != 0) ? 1 : 0);
        if (got.size() > 0) chk(got[0], c * 2 + n);
        got.delete();
        st[c] = n;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(56540));
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        rd(8'h14, 32'h1388);
        rd(8'h10, 32'h0);
        xfer(8'hfc, 1'h1, 32'hffff_ffff);
        rd(8'hfc, 32'h0);
        xfer(8'h08, 1'h1, 32'h64);
        // second pass has the sensor off: no humidity telegram may follow
        for (int k = 1; k >= 0; k--) begin
            xfer(8'h00, 1'h1, k);
            v = k ? 3000 + $urandom % 5000 : hv + 100 + $urandom % 400;
            if (k) hv = v;
            @(posedge clk);
            hum <= v[15:0];
            hvalid <= 1'h1;
            @(posedge clk);
            hvalid <= 1'h0;
            repeat (10) @(posedge clk);
            chk(hq.size(), 1);
        end
        chk(hq[0], hv);
        xfer(8'h00, 1'h1, 32'h1);
        @(posedge clk);
        hum <= 16'd3000;
        fl = '{0, 1};
        th = '{5000, 2000};
        hy = '{1000, 0};
        st = '{0, 0};
        xfer(8'h14, 1'h1, 32'd5000);
        xfer(8'h10, 1'h1, 32'h0100_800c);
        // mode before threshold: the two resulting telegrams stay cycles apart
        xfer(8'h20, 1'h1, 32'h0000_804d);
        xfer(8'h24, 1'h1, 32'd2000);
        repeat (8) @(posedge clk);
        got.delete();
        step(0, 5001 + $urandom % 4000, 0, 1);
        step(0, 4500, 0, 1);
        step(0, 3999, 0, 1);
        ext(2'h2, 1'h0, 16'h0080);
        rd(8'h28, 32'd5019);
        ext(2'h2, 1'h1, 16'h03e8);
        rd(8'h28, 32'd5019);
        th[1] = 5019;
        step(1, 3999, 0, 1);
        xfer(8'h00, 1'h1, 32'h3);
        rd(8'h28, 32'd2000);
        th[1] = 2000;
        step(1, 3999, 0, 1);
        xfer(8'h10, 1'h1, 32'h0100_806c);
        @(posedge clk);
        teach <= 2'h3;
        @(posedge clk);
        teach <= 2'h0;
        rd(8'h18, 32'd3999);
        rd(8'h28, 32'd2000);
        th[0] = 3999;
        step(0, 4500, 0, 1);
        xfer(8'h10, 1'h1, 32'h0100_916c);
        step(0, 2000, 30, 1);
        step(0, 6000, 30, 1);
        th[0] = 5000;
        xfer(8'h10, 1'h1, 32'h0100_8004);
        step(0, 3000, 0, 0);
        xfer(8'h10, 1'h1, 32'h0101_8004);
        repeat (250) @(posedge clk);
        chk(got.size(), 0);
        xfer(8'h10, 1'h1, 32'h0101_000c);
        repeat (350) @(posedge clk);
        chk(got.size() inside {[3:4]}, 1);
        chk(got[0], 0);
        xfer(8'h10, 1'h1, 32'h0100_000c);
        got.delete();
        st[0] = 0;
        step(0, 6000, 200, 0);
        wrap_up();
    end
endmodule // tb_hlv_evaluator
`default_nettype wire
